// file: design/usb_endpoint_handshake_defs.vh
`ifndef USB_ENDPOINT_HANDSHAKE_DEFS_VH
`define USB_ENDPOINT_HANDSHAKE_DEFS_VH
`define PID_OUT 4'h1
`define PID_IN 4'h9
`define PID_SETUP 4'hD
`define PID_DATA0 4'h3
`define PID_DATA1 4'hB
`define PID_ACK 4'h2
`define PID_NAK 4'hA
`define PID_STALL 4'hE
`define CTRL_MAX_BYTES 7'h20
`define BULK_MAX_BYTES 7'h40
`define BULK_EP_NUM 4'h1
`define CTRL_EP_NUM 4'h0
`define DESC_CMD_CODE 8'hC7
`define DESC_UPDATE_LIMIT 2'h3
`define HS_NONE 3'h0
`define HS_ACK 3'h1
`define HS_NAK 3'h2
`define HS_STALL 3'h3
`define HS_ZLP 3'h4
`define HS_DATA 3'h5
`endif

// file: design/usb_endpoint_handshake.v
// Operation
// - control data packets carry at most 32 bytes payload
// - all control transfer stages are handled in hardware
// - setup stage acked only when setup data arrives intact
// - control write data: ACK good, NAK busy, silent corrupt, STALL error
// - control write status IN: zero-length data, STALL error, NAK busy
// - control read IN: DATA, STALL on error, NAK when not ready
// - control read status: ACK good, STALL error, NAK busy
// - bulk packets carry at most 64 bytes payload
// - bulk IN: DATA if queued, STALL error, NAK empty, silent bad token
// - bulk OUT: ACK, STALL error, NAK busy, silent on corruption
// - serial messages pass unchanged as bulk payload
// - descriptor ids and strings are replaceable by the host
// - string update command 0xC7 accepted at most three times
`timescale 1ns/1ps
`include "usb_endpoint_handshake_defs.vh"
module usb_endpoint_handshake (
    // clock, reset, enable
    input wire ref_clk_i,
    input wire reset_n_i,
    input wire clk_en_i,
    // decoded packet from the serial engine
    input wire pkt_valid_i,
    input wire [3:0] pkt_pid_i,
    input wire [3:0] pkt_ep_i,
    input wire pkt_ok_i,
    input wire [6:0] pkt_len_i,
    input wire [7:0] pkt_first_byte_i,
    input wire setup_dir_in_i,
    input wire setup_has_data_i,
    // status from the request and message processors
    input wire ctrl_busy_i,
    input wire ctrl_error_i,
    input wire ctrl_data_ready_i,
    input wire bulk_in_ready_i,
    input wire bulk_in_error_i,
    input wire bulk_out_busy_i,
    input wire bulk_out_error_i,
    // handshake choice
    output reg hs_valid_o,
    output reg [2:0] hs_kind_o,
    output reg [3:0] hs_ep_o,
    // payload hand-offs, descriptor update count, control stage
    output reg bulk_out_accept_o,
    output reg bulk_in_sent_o,
    output reg ctrl_out_accept_o,
    output reg ctrl_in_sent_o,
    output reg desc_update_o,
    output reg [1:0] desc_updates_used_o,
    output reg [1:0] ctrl_stage_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_DATA = 2'd1;
    localparam ST_STATUS = 2'd2;

    reg [1:0] stage_reg;
    reg [1:0] stage_next;
    reg dir_in_reg;
    reg dir_in_next;
    reg xfer_err_reg;
    reg xfer_err_next;

    // last token, held so that its data packet can be judged
    reg [3:0] tok_pid_reg;
    reg [3:0] tok_ep_reg;
    reg tok_ok_reg;
    reg tok_wait_reg;
    reg pend_in_reg;
    reg [1:0] desc_cnt_reg;

    reg [2:0] kind_next;
    reg bo_acc;
    reg bi_snt;
    reg co_acc;
    reg ci_snt;
    reg dup;

    wire data_pkt;
    wire token_in;
    wire token_out;
    wire hs_ack_pkt;
    wire ep_is_ctrl;
    wire ep_is_bulk;
    wire tok_is_ctrl;
    wire tok_is_bulk;
    wire ctrl_fault;

    function is_data;
        input [3:0] pid;
        begin
            is_data = (pid == `PID_DATA0) || (pid == `PID_DATA1);
        end
    endfunction

    // answer to a data packet the device must take in
    function [2:0] out_answer;
        input err;
        input busy;
        begin
            if (err) begin
                out_answer = `HS_STALL;
            end else if (busy) begin
                out_answer = `HS_NAK;
            end else begin
                out_answer = `HS_ACK;
            end
        end
    endfunction

    // answer to an IN token; payload is full data or zero length
    function [2:0] in_answer;
        input err;
        input ready;
        input [2:0] payload;
        begin
            if (err) begin
                in_answer = `HS_STALL;
            end else if (ready) begin
                in_answer = payload;
            end else begin
                in_answer = `HS_NAK;
            end
        end
    endfunction

    function too_long;
        input [6:0] len;
        input [6:0] limit;
        begin
            too_long = (len > limit);
        end
    endfunction

    assign data_pkt = pkt_valid_i && is_data(pkt_pid_i);
    assign token_in = pkt_valid_i && (pkt_pid_i == `PID_IN);
    assign token_out = pkt_valid_i && pkt_ok_i && (pkt_pid_i == `PID_OUT);
    assign hs_ack_pkt = pkt_valid_i && (pkt_pid_i == `PID_ACK);
    assign ep_is_ctrl = (pkt_ep_i == `CTRL_EP_NUM);
    assign ep_is_bulk = (pkt_ep_i == `BULK_EP_NUM);
    assign tok_is_ctrl = (tok_ep_reg == `CTRL_EP_NUM);
    assign tok_is_bulk = (tok_ep_reg == `BULK_EP_NUM);
    assign ctrl_fault = xfer_err_reg || ctrl_error_i;

    // a previous IN answer counts as delivered only after the host ACK
    always @* begin
        stage_next = stage_reg;
        dir_in_next = dir_in_reg;
        xfer_err_next = xfer_err_reg | ctrl_error_i;
        kind_next = `HS_NONE;
        bo_acc = 1'b0;
        bi_snt = 1'b0;
        co_acc = 1'b0;
        ci_snt = 1'b0;
        dup = 1'b0;
        if (data_pkt && tok_wait_reg) begin
            if (!tok_ok_reg || !pkt_ok_i) begin
                kind_next = `HS_NONE;
            end else if (tok_pid_reg == `PID_SETUP) begin
                kind_next = `HS_ACK;
                dir_in_next = setup_dir_in_i;
                xfer_err_next = 1'b0;
                if (setup_has_data_i) begin
                    stage_next = ST_DATA;
                end else begin
                    stage_next = ST_STATUS;
                end
            end else if (tok_is_bulk) begin
                kind_next = out_answer(bulk_out_error_i ||
                    too_long(pkt_len_i, `BULK_MAX_BYTES), bulk_out_busy_i);
                bo_acc = (kind_next == `HS_ACK);
                dup = bo_acc && (pkt_first_byte_i == `DESC_CMD_CODE) &&
                      (desc_cnt_reg != `DESC_UPDATE_LIMIT);
            end else if (tok_is_ctrl && stage_reg == ST_DATA && !dir_in_reg) begin
                kind_next = out_answer(ctrl_fault ||
                    too_long(pkt_len_i, `CTRL_MAX_BYTES), ctrl_busy_i);
                co_acc = (kind_next == `HS_ACK);
                if (kind_next == `HS_STALL) begin
                    xfer_err_next = 1'b1;
                end
            end else if (tok_is_ctrl && dir_in_reg && stage_reg != ST_IDLE) begin
                kind_next = out_answer(ctrl_fault || (pkt_len_i != 7'h00), ctrl_busy_i);
                if (kind_next == `HS_ACK) begin
                    stage_next = ST_IDLE;
                end
            end else begin
                kind_next = `HS_STALL;
            end
        end else if (token_in) begin
            if (!pkt_ok_i) begin
                kind_next = `HS_NONE;
            end else if (ep_is_bulk) begin
                kind_next = in_answer(bulk_in_error_i, bulk_in_ready_i, `HS_DATA);
            end else if (ep_is_ctrl && dir_in_reg && stage_reg == ST_DATA) begin
                kind_next = in_answer(ctrl_fault, ctrl_data_ready_i, `HS_DATA);
            end else if (ep_is_ctrl && !dir_in_reg && stage_reg != ST_IDLE) begin
                kind_next = in_answer(ctrl_fault, !ctrl_busy_i, `HS_ZLP);
            end else begin
                kind_next = `HS_STALL;
            end
        end else if (hs_ack_pkt && pend_in_reg) begin
            if (tok_is_bulk) begin
                bi_snt = 1'b1;
            end else if (stage_reg == ST_STATUS || !dir_in_reg) begin
                stage_next = ST_IDLE;
            end else begin
                ci_snt = 1'b1;
                stage_next = ST_DATA;
            end
        end
        if (token_out && ep_is_ctrl && dir_in_reg && stage_reg == ST_DATA) begin
            stage_next = ST_STATUS;
        end
    end

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage_reg <= ST_IDLE;
            dir_in_reg <= 1'b0;
            xfer_err_reg <= 1'b0;
        end else if (clk_en_i) begin
            stage_reg <= stage_next;
            dir_in_reg <= dir_in_next;
            xfer_err_reg <= xfer_err_next;
        end
    end

    // the token stands until its data packet or a newer packet arrives
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tok_pid_reg <= 4'h0;
            tok_ep_reg <= 4'h0;
            tok_ok_reg <= 1'b0;
            tok_wait_reg <= 1'b0;
            pend_in_reg <= 1'b0;
        end else if (clk_en_i && pkt_valid_i) begin
            if (pkt_pid_i == `PID_SETUP || pkt_pid_i == `PID_OUT) begin
                tok_pid_reg <= pkt_pid_i;
                tok_ep_reg <= pkt_ep_i;
                tok_ok_reg <= pkt_ok_i;
                tok_wait_reg <= 1'b1;
                pend_in_reg <= 1'b0;
            end else if (pkt_pid_i == `PID_IN) begin
                tok_ep_reg <= pkt_ep_i;
                tok_wait_reg <= 1'b0;
                pend_in_reg <= (kind_next == `HS_DATA) || (kind_next == `HS_ZLP);
            end else begin
                tok_wait_reg <= 1'b0;
                pend_in_reg <= 1'b0;
            end
        end
    end

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hs_valid_o <= 1'b0;
            hs_kind_o <= `HS_NONE;
            hs_ep_o <= 4'h0;
        end else if (clk_en_i) begin
            hs_valid_o <= pkt_valid_i && (kind_next != `HS_NONE);
            // kind stands until the next packet so the ACK can be matched
            if (pkt_valid_i) begin
                hs_kind_o <= kind_next;
            end
            if (token_in) begin
                hs_ep_o <= pkt_ep_i;
            end else if (data_pkt) begin
                hs_ep_o <= tok_ep_reg;
            end
        end
    end

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bulk_out_accept_o <= 1'b0;
            bulk_in_sent_o <= 1'b0;
            ctrl_out_accept_o <= 1'b0;
            ctrl_in_sent_o <= 1'b0;
            desc_update_o <= 1'b0;
        end else if (clk_en_i) begin
            bulk_out_accept_o <= bo_acc;
            bulk_in_sent_o <= bi_snt;
            ctrl_out_accept_o <= co_acc;
            ctrl_in_sent_o <= ci_snt;
            desc_update_o <= dup;
        end
    end

    // only a reset gives back spent updates; the cap is otherwise final
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            desc_cnt_reg <= 2'h0;
            desc_updates_used_o <= 2'h0;
        end else if (clk_en_i && dup) begin
            desc_cnt_reg <= desc_cnt_reg + 2'h1;
            desc_updates_used_o <= desc_cnt_reg + 2'h1;
        end
    end

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_stage_o <= ST_IDLE;
        end else if (clk_en_i) begin
            ctrl_stage_o <= stage_next;
        end
    end
endmodule

// file: tb/usb_endpoint_handshake_checker.sv
`timescale 1ns/1ps
module usb_endpoint_handshake_checker (
    // inputs
    input wire ref_clk_i, input wire reset_n_i, input wire clk_en_i, input wire pkt_valid_i,
    input wire [3:0] pkt_pid_i, input wire [3:0] pkt_ep_i, input wire pkt_ok_i,
    input wire [6:0] pkt_len_i, input wire bulk_in_ready_i, input wire bulk_in_error_i,
    input wire bulk_out_busy_i, input wire bulk_out_error_i,
    // outputs
    input wire hs_valid_o, input wire [2:0] hs_kind_o, input wire bulk_in_sent_o,
    input wire desc_update_o, input wire [1:0] desc_updates_used_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // a packet only counts while the clock enable is high
    wire ok = clk_en_i && pkt_valid_i && pkt_ok_i;
    wire dat = ok && pkt_pid_i[2:0] == 3'h3;
    wire bin = ok && pkt_pid_i == 4'h9 && pkt_ep_i == 4'h1 && !bulk_in_error_i;
    wire bout = ok && pkt_pid_i == 4'h1 && pkt_ep_i == 4'h1;
    wire idle = !bulk_out_busy_i && !bulk_out_error_i;
    wire [3:0] ans = {hs_valid_o, hs_kind_o};
    a_corrupt_silent: assert property (clk_en_i && pkt_valid_i && !pkt_ok_i |=> !hs_valid_o)
        else $error("corrupt packet answered");
    a_in_nak: assert property (bin && !bulk_in_ready_i |=> ans == 4'hA)
        else $error("no nak");
    a_in_data: assert property (bin && bulk_in_ready_i |=> ans == 4'hD)
        else $error("no data");
    a_in_sent: assert property (hs_kind_o == 3'h5 && ok && pkt_pid_i == 4'h2
        && pkt_ep_i == 4'h1 |=> bulk_in_sent_o) else $error("ack lost");
    a_out_ack: assert property (bout ##2 dat && pkt_len_i <= 7'h40 && idle |=> ans == 4'h9)
        else $error("no ack");
    a_out_big: assert property (bout ##2 dat && pkt_len_i > 7'h40 |=> ans == 4'hB)
        else $error("oversize taken");
    a_setup_ack: assert property (ok && pkt_pid_i == 4'hD ##2 dat |=> ans == 4'h9)
        else $error("setup not acked");
    a_update_cap: assert property (desc_updates_used_o == 2'h3 |=> !desc_update_o)
        else $error("fourth update");
    cover property (bin ##1 ans == 4'hD);
    cover property (bout ##2 dat ##1 ans == 4'hB);
    cover property (desc_updates_used_o == 2'h3);
endmodule
bind usb_endpoint_handshake usb_endpoint_handshake_checker chk (.ref_clk_i, .reset_n_i, .clk_en_i,
    .pkt_valid_i, .pkt_pid_i, .pkt_ep_i, .pkt_ok_i, .pkt_len_i, .bulk_in_ready_i,
    .bulk_in_error_i, .bulk_out_busy_i, .bulk_out_error_i, .hs_valid_o, .hs_kind_o,
    .bulk_in_sent_o, .desc_update_o, .desc_updates_used_o);

// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
    // clock and answer
    input wire ref_clk_i, input wire hs_valid_i, input wire [2:0] hs_kind_i,
    // packets
    output logic pkt_valid_o = 0, output logic [3:0] pkt_pid_o = 0,
    output logic [3:0] pkt_ep_o = 0, output logic pkt_ok_o = 0,
    output logic [6:0] pkt_len_o = 0, output logic [7:0] pkt_first_byte_o = 0
);
    task pkt(input [3:0] p, input [3:0] e, input k, input [6:0] l, input [7:0] f);
        @(negedge ref_clk_i);
        {pkt_valid_o, pkt_pid_o, pkt_ep_o, pkt_ok_o, pkt_len_o, pkt_first_byte_o} =
            {1'b1, p, e, k, l, f};
        @(negedge ref_clk_i);
        // stale fields would hide a decode that ignores valid
        {pkt_valid_o, pkt_pid_o, pkt_ep_o, pkt_first_byte_o} = {1'b0, ~p, ~e, ~f};
    endtask
    task out_xfer(input [3:0] t, input [3:0] e, input [6:0] l, input [7:0] f);
        pkt(t, e, 1'b1, 7'h00, 8'h00);
        pkt(4'h3, e, 1'b1, l, f);
    endtask
    task in_xfer(input [3:0] e, output [3:0] r);
        pkt(4'h9, e, 1'b1, 7'h00, 8'h00);
        r = {hs_valid_i, hs_kind_i};
        if (r[3] && r[2])
            pkt(4'h2, e, 1'b1, 7'h00, 8'h00);
    endtask
endmodule

// file: tb/usb_endpoint_handshake_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("Error %0t wrong value", $time); end end
module usb_endpoint_handshake_test;
    logic ref_clk_i = 0;
    logic reset_n_i = 0;
    logic en = 1;
    // ctrl busy/err/ready, bulk in ready/err, bulk out busy/err, setup dir/data
    logic [8:0] st = 9'h000;
    logic [3:0] r;
    int errors = 0;
    int checked = 0;
    int n_upd = 0;
    wire pv, po, hv, sent, upd, coa, cis, boa;
    wire [3:0] pp, pe, hep;
    wire [1:0] stg;
    wire [6:0] pl;
    wire [7:0] pf;
    wire [2:0] hk;
    wire [1:0] used;
    always #4 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) n_upd <= n_upd + upd;
    usb_endpoint_handshake uut (.ref_clk_i, .reset_n_i, .clk_en_i(en), .pkt_valid_i(pv),
        .pkt_pid_i(pp), .pkt_ep_i(pe), .pkt_ok_i(po), .pkt_len_i(pl), .pkt_first_byte_i(pf),
        .setup_dir_in_i(st[7]), .setup_has_data_i(st[8]), .ctrl_busy_i(st[0]),
        .ctrl_error_i(st[1]), .ctrl_data_ready_i(st[2]), .bulk_in_ready_i(st[3]),
        .bulk_in_error_i(st[4]), .bulk_out_busy_i(st[5]), .bulk_out_error_i(st[6]),
        .hs_valid_o(hv), .hs_kind_o(hk), .hs_ep_o(hep), .bulk_out_accept_o(boa),
        .bulk_in_sent_o(sent), .ctrl_out_accept_o(coa), .ctrl_in_sent_o(cis),
        .desc_update_o(upd), .desc_updates_used_o(used), .ctrl_stage_o(stg));
    host_model host (.ref_clk_i, .hs_valid_i(hv), .hs_kind_i(hk), .pkt_valid_o(pv),
        .pkt_pid_o(pp), .pkt_ep_o(pe), .pkt_ok_o(po), .pkt_len_o(pl), .pkt_first_byte_o(pf));
    task xo(input [8:0] s, input [3:0] t, input [3:0] e, input [6:0] l, input [7:0] f,
            input [3:0] x);
        st = s;
        host.out_xfer(t, e, l, f);
        `CHK({hv, hk}, x)
    endtask
    task xi(input [8:0] s, input [3:0] e, input [3:0] x);
        st = s;
        host.in_xfer(e, r);
        `CHK(r, x)
    endtask
    task t_ctrl;
        xo(9'h100, 4'hD, 4'h0, 7'h08, 8'h00, 4'h9);
        `CHK(stg, 2'h1)
        xo(9'h101, 4'h1, 4'h0, 7'h20, 8'h00, 4'hA);
        xo(9'h100, 4'h1, 4'h0, 7'h20, 8'h00, 4'h9);
        `CHK(coa, 1'b1)
        xi(9'h101, 4'h0, 4'hA);
        xi(9'h100, 4'h0, 4'hC);
        `CHK(stg, 2'h0)
        xo(9'h180, 4'hD, 4'h0, 7'h08, 8'h00, 4'h9);
        xi(9'h184, 4'h0, 4'hD);
        `CHK(cis, 1'b1)
        xo(9'h000, 4'h1, 4'h0, 7'h00, 8'h00, 4'h9);
        `CHK(stg, 2'h0)
        $display("control transfers done");
    endtask
    task t_bulk;
        xi(9'h000, 4'h1, 4'hA);
        xi(9'h008, 4'h1, 4'hD);
        `CHK(sent, 1'b1)
        xi(9'h018, 4'h1, 4'hB);
        host.pkt(4'h9, 4'h1, 1'b0, 7'h00, 8'h00);
        `CHK(hv, 1'b0)
        en = 0;
        host.pkt(4'h9, 4'h1, 1'b1, 7'h00, 8'h00);
        `CHK(hv, 1'b0)
        en = 1;
        xo(9'h000, 4'h1, 4'h1, 7'h40, 8'h00, 4'h9);
        `CHK(boa, 1'b1)
        `CHK(hep, 4'h1)
        xo(9'h000, 4'h1, 4'h1, 7'h41, 8'h00, 4'hB);
        xo(9'h020, 4'h1, 4'h1, 7'h08, 8'h00, 4'hA);
        xo(9'h040, 4'h1, 4'h1, 7'h08, 8'h00, 4'hB);
        $display("bulk transfers done");
    endtask
    task t_desc;
        repeat (4) xo(9'h000, 4'h1, 4'h1, 7'h08, 8'hC7, 4'h9);
        repeat (2) @(negedge ref_clk_i);
        `CHK(n_upd, 3)
        `CHK(used, 2'h3)
        $display("descriptor updates done");
    endtask
    task wrap_up;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge ref_clk_i);
        reset_n_i = 1;
        t_ctrl;
        t_bulk;
        t_desc;
        wrap_up;
    end
    // whole run is under 100 packets of two cycles each
    initial begin
        #20000;
        errors++;
        wrap_up;
    end
endmodule
